// file: core/rlc_pkg.sv
// package: register map, field layout and decode of the line resistor control
package rlc_pkg;

	localparam int              ADDR_W          = 4;
	localparam int              DATA_W          = 32;
	localparam int              STRB_W          = DATA_W / 8;

	localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;

	localparam int              CTRL_XCVR_LSB   = 0;
	localparam int              CTRL_TERM_BIT   = 2;
	localparam int              CTRL_OPERATING_MODE_FIELD_LSB = 3;
	localparam int              CTRL_DP_PD_BIT  = 5;
	localparam int              CTRL_DM_PD_BIT  = 6;

	localparam int              STAT_RPU_BIT    = 0;
	localparam int              STAT_RPD_DP_BIT = 1;
	localparam int              STAT_RPD_DM_BIT = 2;
	localparam int              STAT_HSTERM_BIT = 3;
	localparam int              STAT_TRI_BIT    = 4;

	localparam logic [1:0]      XCVR_HS         = 2'h0;
	localparam logic [1:0]      XCVR_FS         = 2'h1;
	localparam logic [1:0]      XCVR_LS         = 2'h2;
	localparam logic [1:0]      OPERATING_MODE_FIELD_NORMAL   = 2'h0;
	localparam logic [1:0]      OPERATING_MODE_FIELD_TRISTATE = 2'h1;
	localparam logic [1:0]      OPERATING_MODE_FIELD_CHIRP    = 2'h2;

	localparam logic [1:0]      RESP_OKAY       = 2'h0;
	localparam logic [1:0]      RESP_SLVERR     = 2'h2;

	typedef struct packed {
		logic [1:0] transceiver_select;
		logic       termination_select;
		logic [1:0] operating_mode_field;
		logic       plus_line_pull_low_bit;
		logic       minus_line_pull_low_bit;
	} rlc_fields_s;

	typedef struct packed {
		logic rpu;
		logic rpd_dp;
		logic rpd_dm;
		logic hsterm;
		logic tristate;
	} rlc_res_s;

	localparam rlc_fields_s FIELDS_RESET = '{XCVR_FS, 1'b0, OPERATING_MODE_FIELD_NORMAL, 1'b1, 1'b1};
	localparam rlc_res_s    RES_RESET    = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	localparam rlc_res_s    RES_TRISTATE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} rlc_wr_e;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rlc_rd_e;

	function automatic rlc_res_s rlc_decode(input rlc_fields_s f);
		rlc_res_s r;
		r = RES_TRISTATE;
		if (f.operating_mode_field != OPERATING_MODE_FIELD_TRISTATE) begin
			r.tristate = 1'b0;
			r.rpd_dp   = f.plus_line_pull_low_bit;
			r.rpd_dm   = f.minus_line_pull_low_bit;
			r.rpu      = f.termination_select & ~f.plus_line_pull_low_bit;
			r.hsterm   = ~f.termination_select & (f.transceiver_select == XCVR_HS);
		end
		return r;
	endfunction : rlc_decode

	function automatic rlc_fields_s rlc_fields_from_word(input logic [DATA_W-1:0] d);
		rlc_fields_s f;
		f.transceiver_select      = d[CTRL_XCVR_LSB +: 2];
		f.termination_select      = d[CTRL_TERM_BIT];
		f.operating_mode_field    = d[CTRL_OPERATING_MODE_FIELD_LSB +: 2];
		f.plus_line_pull_low_bit  = d[CTRL_DP_PD_BIT];
		f.minus_line_pull_low_bit = d[CTRL_DM_PD_BIT];
		return f;
	endfunction : rlc_fields_from_word

	function automatic logic [DATA_W-1:0] rlc_word_from_fields(input rlc_fields_s f);
		logic [DATA_W-1:0] d;
		d = '0;
		d[CTRL_XCVR_LSB +: 2]   = f.transceiver_select;
		d[CTRL_TERM_BIT]        = f.termination_select;
		d[CTRL_OPERATING_MODE_FIELD_LSB +: 2] = f.operating_mode_field;
		d[CTRL_DP_PD_BIT]       = f.plus_line_pull_low_bit;
		d[CTRL_DM_PD_BIT]       = f.minus_line_pull_low_bit;
		return d;
	endfunction : rlc_word_from_fields

	function automatic logic [DATA_W-1:0] rlc_word_from_res(input rlc_res_s r);
		logic [DATA_W-1:0] d;
		d = '0;
		d[STAT_RPU_BIT]    = r.rpu;
		d[STAT_RPD_DP_BIT] = r.rpd_dp;
		d[STAT_RPD_DM_BIT] = r.rpd_dm;
		d[STAT_HSTERM_BIT] = r.hsterm;
		d[STAT_TRI_BIT]    = r.tristate;
		return d;
	endfunction : rlc_word_from_res

endpackage : rlc_pkg

// file: core/rlc_res_if.sv
// interface: register fields to the decoder and resistor enables back
`timescale 1ns/1ns
`default_nettype none
interface rlc_res_if;
	rlc_pkg::rlc_fields_s fields;
	rlc_pkg::rlc_res_s    enables;
	modport ctrl (output fields, input enables);
	modport dec  (input fields, output enables);
endinterface : rlc_res_if
`default_nettype wire

// file: core/rlc_decoder.sv
// resistor enable decoder with registered outputs
`timescale 1ns/1ns
`default_nettype none
module rlc_decoder (
	input  wire logic aclk,
	input  wire logic aresetn,
	rlc_res_if.dec    res
);
	import rlc_pkg::*;

	typedef struct packed {
		rlc_res_s res;
	} rlc_dec_state_s;

	rlc_dec_state_s state_reg;
	rlc_dec_state_s state_next;

	// registered so the analog switches never see decode glitches
	always_comb begin
		state_next     = state_reg;
		state_next.res = rlc_decode(res.fields);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '{res: RES_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign res.enables = state_reg.res;

	property p_rpu;
		@(posedge aclk) disable iff (!aresetn)
		(res.fields.operating_mode_field != OPERATING_MODE_FIELD_TRISTATE) |=>
			(res.enables.rpu == ($past(res.fields.termination_select)
			&& !$past(res.fields.plus_line_pull_low_bit)));
	endproperty
	a_rpu: assert property (p_rpu) else $error("pull-up enable wrong");

	property p_rpd_dp;
		@(posedge aclk) disable iff (!aresetn)
		(res.fields.operating_mode_field != OPERATING_MODE_FIELD_TRISTATE) |=>
			(res.enables.rpd_dp == $past(res.fields.plus_line_pull_low_bit));
	endproperty
	a_rpd_dp: assert property (p_rpd_dp) else $error("plus pull-down wrong");

	property p_rpd_dm;
		@(posedge aclk) disable iff (!aresetn)
		(res.fields.operating_mode_field != OPERATING_MODE_FIELD_TRISTATE) |=>
			(res.enables.rpd_dm == $past(res.fields.minus_line_pull_low_bit));
	endproperty
	a_rpd_dm: assert property (p_rpd_dm) else $error("minus pull-down wrong");

	property p_hsterm;
		@(posedge aclk) disable iff (!aresetn)
		(res.fields.operating_mode_field != OPERATING_MODE_FIELD_TRISTATE) |=>
			(res.enables.hsterm == (!$past(res.fields.termination_select)
			&& ($past(res.fields.transceiver_select) == XCVR_HS)));
	endproperty
	a_hsterm: assert property (p_hsterm) else $error("termination enable wrong");

	property p_tristate;
		@(posedge aclk) disable iff (!aresetn)
		(res.fields.operating_mode_field == OPERATING_MODE_FIELD_TRISTATE) |=>
			(res.enables == RES_TRISTATE);
	endproperty
	a_tristate: assert property (p_tristate) else $error("3-state not all off");

	property p_reset;
		@(posedge aclk)
		!aresetn |=> (res.enables == RES_RESET);
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : rlc_decoder
`default_nettype wire

// file: core/rlc_top.sv
// line resistor control: axi4-lite register slave driving the resistor decoder
//
// Operation
// - the plus line pull-up is switched in exactly while its decoded enable is high.
// - the plus line pull-down is switched in exactly while its decoded enable is high.
// - the minus line pull-down is switched in exactly while its decoded enable is high.
// - the high-speed terminations on both lines follow their decoded enable.
// - all four enables depend only on the five programmed register fields.
// - operating mode 01b turns every enable off and puts the drivers in 3-state.
// - host suspend settings give both pull-downs on, pull-up and termination off.
// - host resume settings give both pull-downs on, pull-up and termination off.
// - host test J/K settings give both pull-downs and termination on, pull-up off.
// - otg peripheral chirp gives pull-up and minus pull-down on, the rest off.
// - otg peripheral full-speed gives pull-up and minus pull-down on, the rest off.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rlc_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [rlc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [rlc_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [rlc_pkg::STRB_W-1:0] s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [rlc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [rlc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       plus_line_pullup_enable,
	output logic                       plus_line_pulldown_enable,
	output logic                       minus_line_pulldown_enable,
	output logic                       high_speed_termination_enable,
	output logic                       line_drivers_tristate
);
	import rlc_pkg::*;

	localparam logic [1:0] SEL_NONE   = 2'h0;
	localparam logic [1:0] SEL_CTRL   = 2'h1;
	localparam logic [1:0] SEL_STATUS = 2'h2;

	typedef struct packed {
		rlc_fields_s        fields;
		rlc_wr_e            wstate;
		logic               aw_held;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_held;
		logic [DATA_W-1:0]  w_data;
		logic [STRB_W-1:0]  w_strb;
		logic [1:0]         bresp;
		rlc_rd_e            rstate;
		logic [DATA_W-1:0]  rdata;
		logic [1:0]         rresp;
	} rlc_top_state_s;

	localparam rlc_top_state_s STATE_RESET = '{
		fields:  FIELDS_RESET,
		wstate:  WR_IDLE,
		aw_held: 1'b0,
		aw_addr: '0,
		w_held:  1'b0,
		w_data:  '0,
		w_strb:  '0,
		bresp:   RESP_OKAY,
		rstate:  RD_IDLE,
		rdata:   '0,
		rresp:   RESP_OKAY
	};

	rlc_top_state_s state_reg;
	rlc_top_state_s state_next;

	rlc_res_if res_if ();

	// low address bits are ignored; any word outside the two registers is unmapped
	function automatic logic [1:0] rlc_sel(input logic [ADDR_W-1:0] a);
		logic [1:0] s;
		s = SEL_NONE;
		if (a[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
			s = SEL_CTRL;
		end else if (a[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
			s = SEL_STATUS;
		end
		return s;
	endfunction : rlc_sel

	logic [1:0] wr_sel;
	logic [1:0] ar_sel;
	logic       wr_fire;

	assign wr_sel  = rlc_sel(state_reg.aw_addr);
	assign ar_sel  = rlc_sel(s_axi_araddr);
	assign wr_fire = (state_reg.wstate == WR_IDLE) && state_reg.aw_held && state_reg.w_held;

	// address and data are latched separately so either may arrive first
	assign s_axi_awready = (state_reg.wstate == WR_IDLE) && !state_reg.aw_held;
	assign s_axi_wready  = (state_reg.wstate == WR_IDLE) && !state_reg.w_held;
	assign s_axi_bvalid  = (state_reg.wstate == WR_RESP);
	assign s_axi_bresp   = state_reg.bresp;
	assign s_axi_arready = (state_reg.rstate == RD_IDLE);
	assign s_axi_rvalid  = (state_reg.rstate == RD_DATA);
	assign s_axi_rdata   = state_reg.rdata;
	assign s_axi_rresp   = state_reg.rresp;

	always_comb begin
		state_next = state_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_held = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		case (state_reg.wstate)
			WR_IDLE: begin
				if (wr_fire) begin
					state_next.aw_held = 1'b0;
					state_next.w_held  = 1'b0;
					state_next.wstate  = WR_RESP;
					state_next.bresp   = RESP_OKAY;
					case (wr_sel)
						SEL_CTRL: begin
							// all fields sit in byte lane 0
							if (state_reg.w_strb[0]) begin
								state_next.fields = rlc_fields_from_word(state_reg.w_data);
							end
						end
						SEL_STATUS: begin
							// status is read-only; the write is dropped but answered okay
						end
						default: begin
							state_next.bresp = RESP_SLVERR;
						end
					endcase
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					state_next.wstate = WR_IDLE;
				end
			end
			default: begin
				state_next.wstate = WR_IDLE;
			end
		endcase
		case (state_reg.rstate)
			RD_IDLE: begin
				if (s_axi_arvalid) begin
					state_next.rstate = RD_DATA;
					state_next.rresp  = RESP_OKAY;
					case (ar_sel)
						SEL_CTRL: begin
							state_next.rdata = rlc_word_from_fields(state_reg.fields);
						end
						SEL_STATUS: begin
							state_next.rdata = rlc_word_from_res(res_if.enables);
						end
						default: begin
							state_next.rdata = '0;
							state_next.rresp = RESP_SLVERR;
						end
					endcase
				end
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					state_next.rstate = RD_IDLE;
				end
			end
			default: begin
				state_next.rstate = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign res_if.fields = state_reg.fields;

	rlc_decoder u_decoder (
		.aclk    (aclk),
		.aresetn (aresetn),
		.res     (res_if)
	);

	// the link owns the choice of signalling state; these pins only reflect its fields
	assign plus_line_pullup_enable       = res_if.enables.rpu;
	assign plus_line_pulldown_enable     = res_if.enables.rpd_dp;
	assign minus_line_pulldown_enable    = res_if.enables.rpd_dm;
	assign high_speed_termination_enable = res_if.enables.hsterm;
	assign line_drivers_tristate         = res_if.enables.tristate;

	logic [3:0]        pins;
	rlc_fields_s       wr_fields;
	logic [DATA_W-1:0] status_word;

	assign pins        = {plus_line_pullup_enable, plus_line_pulldown_enable,
		minus_line_pulldown_enable, high_speed_termination_enable};
	assign wr_fields   = rlc_fields_from_word(state_reg.w_data);
	assign status_word = rlc_word_from_res(res_if.enables);

	property p_ctrl_write;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && (wr_sel == SEL_CTRL) && state_reg.w_strb[0]) |=>
			(res_if.fields == $past(wr_fields)) ##1
			({pins, line_drivers_tristate} == rlc_decode($past(wr_fields, 2)));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied");

	property p_host_suspend;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields == rlc_fields_s'{XCVR_FS, 1'b1, OPERATING_MODE_FIELD_NORMAL, 1'b1, 1'b1}) |=>
			(pins == 4'b0110);
	endproperty
	a_host_suspend: assert property (p_host_suspend) else $error("host suspend decode");

	property p_host_resume;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields == rlc_fields_s'{XCVR_FS, 1'b1, OPERATING_MODE_FIELD_CHIRP, 1'b1, 1'b1}) |=>
			(pins == 4'b0110);
	endproperty
	a_host_resume: assert property (p_host_resume) else $error("host resume decode");

	property p_host_test;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields == rlc_fields_s'{XCVR_HS, 1'b0, OPERATING_MODE_FIELD_CHIRP, 1'b1, 1'b1}) |=>
			(pins == 4'b0111);
	endproperty
	a_host_test: assert property (p_host_test) else $error("host test j/k decode");

	property p_otg_chirp;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields == rlc_fields_s'{XCVR_HS, 1'b1, OPERATING_MODE_FIELD_CHIRP, 1'b0, 1'b1}) |=>
			(pins == 4'b1010);
	endproperty
	a_otg_chirp: assert property (p_otg_chirp) else $error("otg chirp decode");

	property p_otg_fs;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields == rlc_fields_s'{XCVR_FS, 1'b1, OPERATING_MODE_FIELD_NORMAL, 1'b0, 1'b1}) |=>
			(pins == 4'b1010);
	endproperty
	a_otg_fs: assert property (p_otg_fs) else $error("otg full-speed decode");

	property p_tristate_pins;
		@(posedge aclk) disable iff (!aresetn)
		(res_if.fields.operating_mode_field == OPERATING_MODE_FIELD_TRISTATE) [*2] |->
			((pins == 4'b0000) && line_drivers_tristate);
	endproperty
	a_tristate_pins: assert property (p_tristate_pins) else $error("3-state pins not off");

	property p_wr_answer;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid && (s_axi_bresp == (($past(wr_sel) == SEL_NONE) ?
			RESP_SLVERR : RESP_OKAY));
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response wrong");

	property p_b_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");

	property p_rd_answer;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid
			&& (s_axi_rresp == (($past(ar_sel) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY));
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read response wrong");

	property p_status_read;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && (ar_sel == SEL_STATUS)) |=>
			(s_axi_rdata == $past(status_word));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read data wrong");

	property p_r_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");

endmodule : rlc_top
`default_nettype wire

// file: tb/rlc_link_model.sv
// link controller model: axi4-lite master that programs the resistor fields
`timescale 1ns/1ns
`default_nettype none
module rlc_link_model (
	input  wire logic                         aclk,
	output logic [rlc_pkg::ADDR_W-1:0]        awaddr,
	output logic                              awvalid,
	input  wire logic                         awready,
	output logic [rlc_pkg::DATA_W-1:0]        wdata,
	output logic [rlc_pkg::STRB_W-1:0]        wstrb,
	output logic                              wvalid,
	input  wire logic                         wready,
	input  wire logic [1:0]                   bresp,
	input  wire logic                         bvalid,
	output logic                              bready,
	output logic [rlc_pkg::ADDR_W-1:0]        araddr,
	output logic                              arvalid,
	input  wire logic                         arready,
	input  wire logic [rlc_pkg::DATA_W-1:0]   rdata,
	input  wire logic [1:0]                   rresp,
	input  wire logic                         rvalid,
	output logic                              rready
);
	import rlc_pkg::*;

	// b and r ready come late on purpose so every response must stand stalled for a cycle
	initial begin
		awaddr  = '0;
		awvalid = 1'b0;
		wdata   = '0;
		wstrb   = '0;
		wvalid  = 1'b0;
		bready  = 1'b0;
		araddr  = '0;
		arvalid = 1'b0;
		rready  = 1'b0;
	end

	// released addresses and write data show the inverse so a stale value is never mistaken for a live one
	task automatic write_word(
		input  logic [ADDR_W-1:0] addr,
		input  logic [DATA_W-1:0] data,
		input  logic [STRB_W-1:0] strb,
		output logic [1:0]        resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		awaddr  <= addr;
		awvalid <= 1'b1;
		wdata   <= data;
		wstrb   <= strb;
		wvalid  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
				awaddr  <= ~addr;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
				wdata  <= ~data;
			end
		end
		repeat (2) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		resp = bresp;
	endtask : write_word

	task automatic read_word(
		input  logic [ADDR_W-1:0] addr,
		output logic [DATA_W-1:0] data,
		output logic [1:0]        resp);
		araddr  <= addr;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr  <= ~addr;
		@(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		data = rdata;
		resp = rresp;
	endtask : read_word

endmodule : rlc_link_model
`default_nettype wire

// file: tb/test_rlc_top.sv
// self-checking bench for the line resistor control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			fails++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_rlc_top;
	import rlc_pkg::*;

	logic              aclk    = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [DATA_W-1:0] wdata;
	logic [STRB_W-1:0] wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [ADDR_W-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [DATA_W-1:0] rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic [4:0]        pins;
	int                fails       = 0;
	int                checks_done = 0;

	always #5 aclk = ~aclk;

	rlc_top DUT (
		.aclk                          (aclk),
		.aresetn                       (aresetn),
		.s_axi_awaddr                  (awaddr),
		.s_axi_awvalid                 (awvalid),
		.s_axi_awready                 (awready),
		.s_axi_wdata                   (wdata),
		.s_axi_wstrb                   (wstrb),
		.s_axi_wvalid                  (wvalid),
		.s_axi_wready                  (wready),
		.s_axi_bresp                   (bresp),
		.s_axi_bvalid                  (bvalid),
		.s_axi_bready                  (bready),
		.s_axi_araddr                  (araddr),
		.s_axi_arvalid                 (arvalid),
		.s_axi_arready                 (arready),
		.s_axi_rdata                   (rdata),
		.s_axi_rresp                   (rresp),
		.s_axi_rvalid                  (rvalid),
		.s_axi_rready                  (rready),
		.plus_line_pullup_enable       (pins[0]),
		.plus_line_pulldown_enable     (pins[1]),
		.minus_line_pulldown_enable    (pins[2]),
		.high_speed_termination_enable (pins[3]),
		.line_drivers_tristate         (pins[4])
	);

	rlc_link_model link (
		.aclk    (aclk),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// row: control fields in [14:8], expected {tristate, hsterm, dm pd, dp pd, pullup} in [4:0]
	// upper data bits are written as ones to show they never stick
	task automatic run_row(input logic [15:0] row);
		logic [1:0]        resp;
		logic [DATA_W-1:0] rd;
		link.write_word(CTRL_OFFSET, {25'h1ff_ffff, row[14:8]}, 4'hf, resp);
		`CHK("ctrl write resp", RESP_OKAY, resp)
		link.read_word(CTRL_OFFSET, rd, resp);
		`CHK("ctrl readback", {25'h0, row[14:8]}, rd)
		link.read_word(STATUS_OFFSET, rd, resp);
		`CHK("status word", {27'h0, row[4:0]}, rd)
		`CHK("resistor pins", row[4:0], pins)
	endtask : run_row

	task automatic check_reset();
		logic [1:0]        resp;
		logic [DATA_W-1:0] rd;
		`CHK("pins after reset", 5'h06, pins)
		link.read_word(CTRL_OFFSET, rd, resp);
		`CHK("ctrl after reset", 32'h0000_0061, rd)
		link.read_word(STATUS_OFFSET, rd, resp);
		`CHK("status after reset", 32'h0000_0006, rd)
	endtask : check_reset

	initial begin
		repeat (4000) @(posedge aclk);
		fails++;
		$display("Error watchdog expected finish seen timeout");
		end_sim();
	end

	initial begin : main
		logic [1:0]        resp;
		logic [DATA_W-1:0] rd;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_reset();
		$display("test reset done");
		run_row(16'h6F10);
		run_row(16'h0810);
		run_row(16'h6106);
		run_row(16'h700E);
		run_row(16'h600E);
		run_row(16'h6706);
		run_row(16'h6506);
		run_row(16'h7506);
		run_row(16'h6606);
		run_row(16'h7606);
		run_row(16'h1401);
		run_row(16'h0008);
		run_row(16'h0501);
		run_row(16'h1008);
		run_row(16'h5405);
		run_row(16'h400C);
		run_row(16'h4505);
		run_row(16'h500C);
		run_row(16'h700E);
		$display("test decode table done");
		run_row(16'h6506);
		link.write_word(CTRL_OFFSET, 32'h0000_0014, 4'he, resp);
		`CHK("masked write resp", RESP_OKAY, resp)
		link.write_word(STATUS_OFFSET, 32'h0000_001f, 4'hf, resp);
		`CHK("status write resp", RESP_OKAY, resp)
		link.write_word(4'h8, 32'h0000_0014, 4'hf, resp);
		`CHK("unmapped write resp", RESP_SLVERR, resp)
		link.read_word(4'hc, rd, resp);
		`CHK("unmapped read resp", RESP_SLVERR, resp)
		`CHK("unmapped read data", 32'h0000_0000, rd)
		link.read_word(CTRL_OFFSET, rd, resp);
		`CHK("ctrl kept", 32'h0000_0065, rd)
		`CHK("pins kept", 5'h06, pins)
		$display("test refused writes done");
		run_row(16'h5405);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_reset();
		$display("test reset in mid-run done");
		end_sim();
	end

endmodule : test_rlc_top
`undef CHK
`default_nettype wire
